// file: common/ssm_if.sv
// internal carrier between control, baud generator and shifter
`timescale 1ns/1ps
`default_nettype none
interface ssm_if;
	logic       tick;
	logic       run;
	logic [7:0] divisor;
	logic       high_speed;
	logic       load;
	logic [8:0] load_data;
	logic       nine;
	logic       master;
	logic       ext_rise;
	logic       ext_fall;
	logic       abort;
	logic       busy;
	logic       sck;
	logic       sdo;
	modport baud (input run, divisor, high_speed, output tick);
	modport shift (input tick, load, load_data, nine, master, ext_rise, ext_fall, abort,
		output busy, sck, sdo, run);
endinterface
`default_nettype wire

// file: common/ssm_pkg.sv
// shared constants for the synchronous serial master transmitter
package ssm_pkg;
	// ==========================================
	// register map (byte addresses)
	localparam int           ADDR_W      = 5;
	localparam logic [4:0]   ADDR_TXCTL  = 5'h00;
	localparam logic [4:0]   ADDR_RXCTL  = 5'h04;
	localparam logic [4:0]   ADDR_DIV    = 5'h08;
	localparam logic [4:0]   ADDR_HOLD   = 5'h0C;
	localparam logic [4:0]   ADDR_STAT   = 5'h10;
	// ==========================================
	// transmit control fields
	localparam int           TX_CSM      = 7;
	localparam int           TX_N9       = 6;
	localparam int           TX_EN       = 5;
	localparam int           TX_SYNC     = 4;
	localparam int           TX_HSB      = 2;
	localparam int           TX_TRMT     = 1;
	localparam int           TX_N9D      = 0;
	localparam logic [7:0]   TXCTL_WMASK = 8'hF5;
	localparam logic [7:0]   TXCTL_RST   = 8'h02;
	// ==========================================
	// receive control fields
	localparam int           RX_PORT_ENABLE     = 7;
	localparam int           RX_SINGLE_RECEIVE_ENABLE     = 5;
	localparam int           RX_CONTINUOUS_RECEIVE_ENABLE     = 4;
	localparam logic [7:0]   RXCTL_WMASK = 8'hB0;
	localparam logic [7:0]   REG_RST     = 8'h00;
	// ==========================================
	// bus answers, character and prescale figures
	localparam logic [1:0]   RESP_OK     = 2'h0;
	localparam logic [1:0]   RESP_ERR    = 2'h2;
	localparam logic [3:0]   BITS_8      = 4'h8;
	localparam logic [3:0]   BITS_9      = 4'h9;
	localparam logic [2:0]   PRE_LOW     = 3'h4;
	localparam logic [2:0]   PRE_HIGH    = 3'h1;
	typedef enum logic [1:0] {SSM_IDLE = 2'b00, SSM_SHIFT = 2'b01} ssm_state_t;
endpackage

// file: hdl/ssm_baud.sv
// baud generator: half-period enable pulse for the shift clock
`timescale 1ns/1ps
`default_nettype none
module ssm_baud (
	input  wire logic clk,
	input  wire logic rst_n,
	ssm_if.baud       bus
);
	logic [2:0] pre_ff;
	logic [7:0] div_ff;
	logic       tick_ff;
	logic [2:0] lim;

	// high speed bypasses the divide-by-four prescale
	assign lim = bus.high_speed ? ssm_pkg::PRE_HIGH : ssm_pkg::PRE_LOW; // RULE22
	assign bus.tick = tick_ff;

	// ==========================================
	// counters are held clear while idle so the first half period is whole
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_ff  <= 3'h0;
			div_ff  <= 8'h00;
			tick_ff <= 1'b0;
		end else if (!bus.run) begin
			pre_ff  <= 3'h0;
			div_ff  <= 8'h00;
			tick_ff <= 1'b0;
		end else begin
			tick_ff <= 1'b0;
			if (pre_ff == lim - 3'h1) begin // RULE3
				pre_ff <= 3'h0;
				if (div_ff == bus.divisor) begin // RULE22
					div_ff  <= 8'h00;
					tick_ff <= 1'b1;
				end else begin
					div_ff <= div_ff + 8'h01;
				end
			end else begin
				pre_ff <= pre_ff + 3'h1;
			end
		end
	end
endmodule
`default_nettype wire

// file: hdl/ssm_shift.sv
// transmit shift register and shift clock phase
`timescale 1ns/1ps
`default_nettype none
module ssm_shift (
	input  wire logic clk,
	input  wire logic rst_n,
	ssm_if.shift      bus
);
	ssm_pkg::ssm_state_t state_ff;
	logic [8:0]          shreg_ff;
	logic [3:0]          left_ff;
	logic                ph_ff;
	logic                sdo_ff;
	logic                sck_ff;
	logic                lead;
	logic                trail;

	// master edges come from the baud tick, slave edges from the pin
	assign lead  = bus.master ? (bus.tick & ~ph_ff) : (bus.ext_rise & ~ph_ff); // RULE4
	assign trail = bus.master ? (bus.tick & ph_ff) : (bus.ext_fall & ph_ff); // RULE5
	assign bus.busy = (state_ff != ssm_pkg::SSM_IDLE);
	assign bus.run  = bus.master & bus.busy; // RULE3
	// pin copy of the phase kept in its own flop, forced low in slave mode
	assign bus.sck  = sck_ff;
	assign bus.sdo  = sdo_ff;

	// ==========================================
	// data bits only, no framing bits around them
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= ssm_pkg::SSM_IDLE;
			shreg_ff <= 9'h000;
			left_ff  <= 4'h0;
			ph_ff    <= 1'b0;
			sdo_ff   <= 1'b0;
			sck_ff   <= 1'b0;
		end else if (bus.abort) begin
			state_ff <= ssm_pkg::SSM_IDLE;
			ph_ff    <= 1'b0;
			sck_ff   <= 1'b0;
		end else begin
			unique case (state_ff)
				ssm_pkg::SSM_IDLE: begin
					if (bus.load) begin // RULE1
						shreg_ff <= bus.load_data;
						left_ff  <= bus.nine ? ssm_pkg::BITS_9 : ssm_pkg::BITS_8; // RULE23
						state_ff <= ssm_pkg::SSM_SHIFT; // RULE17
					end
				end
				ssm_pkg::SSM_SHIFT: begin
					if (lead) begin
						sdo_ff   <= shreg_ff[0]; // RULE11
						shreg_ff <= {1'b0, shreg_ff[8:1]};
						ph_ff    <= 1'b1;
						sck_ff   <= bus.master; // RULE10
					end else if (trail) begin
						ph_ff   <= 1'b0;
						sck_ff  <= 1'b0;
						left_ff <= left_ff - 4'h1;
						if (left_ff == 4'h1) begin // RULE12
							state_ff <= ssm_pkg::SSM_IDLE;
						end
					end
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// file: hdl/ssm_top.sv
// synchronous serial master transmitter with AXI4-Lite registers
// Overview of operation
// [RULE1] no start or stop bits sent
// [RULE2] one clock line, shared half-duplex data line
// [RULE3] master makes clock from own baud generator
// [RULE4] selectable master or external-clock slave
// [RULE5] slave shifts only on master clock edges
// [RULE6] mode bit set selects synchronous operation
// [RULE7] clock source bit set makes master
// [RULE8] both receive enables clear means transmit
// [RULE9] port runs only with port enable set
// [RULE10] master drives clock pin, driver auto-enabled
// [RULE11] data changes on leading clock edge
// [RULE12] one clock per data bit, else idle
// [RULE13] master transmit enables data and clock drivers
// [RULE14] holding register write starts a transmission
// [RULE15] new character waits while shifter busy
// [RULE16] empty shifter loads held character immediately
// [RULE17] shifting starts right after the load
// [RULE18] data bit stable between leading edges
// [RULE19] shift register has no bus address
// [RULE20] transmission needs transmit enable set
// [RULE21] nine-bit option sends ninth control bit
// [RULE22] divisor and high-speed option set clock
// [RULE23] eight bits, LSB first, unless nine-bit
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ssm_top (
	input  wire logic        CLK,
	input  wire logic        RESET_N,
	input  wire logic [4:0]  AWADDR,
	input  wire logic        AWVALID,
	output logic             AWREADY,
	input  wire logic [31:0] WDATA,
	input  wire logic [3:0]  WSTRB,
	input  wire logic        WVALID,
	output logic             WREADY,
	output logic [1:0]       BRESP,
	output logic             BVALID,
	input  wire logic        BREADY,
	input  wire logic [4:0]  ARADDR,
	input  wire logic        ARVALID,
	output logic             ARREADY,
	output logic [31:0]      RDATA,
	output logic [1:0]       RRESP,
	output logic             RVALID,
	input  wire logic        RREADY,
	input  wire logic        CLOCK_PIN_IN,
	output logic             CLOCK_PIN_OUT,
	output logic             CLOCK_PIN_OE_N,
	input  wire logic        DATA_PIN_IN,
	output logic             DATA_PIN_OUT,
	output logic             DATA_PIN_OE_N
);
	// ==========================================
	// declarations
	logic        rst_meta_ff;
	logic        rst_n;
	logic        ck_s1_ff;
	logic        ck_s2_ff;
	logic        ck_s3_ff;
	logic        dt_s1_ff;
	logic        dt_s2_ff;
	logic [4:0]  aw_addr_ff;
	logic        aw_done_ff;
	logic        awready_ff;
	logic [7:0]  wdata_ff;
	logic        wstrb_ff;
	logic        w_done_ff;
	logic        wready_ff;
	logic        bvalid_ff;
	logic [1:0]  bresp_ff;
	logic        arready_ff;
	logic        rvalid_ff;
	logic [1:0]  rresp_ff;
	logic [31:0] rdata_ff;
	logic [7:0]  txctl_ff;
	logic [7:0]  rxctl_ff;
	logic [7:0]  div_ff;
	logic [7:0]  hold_ff;
	logic        hold_full_ff;
	logic        load_ff;
	logic [8:0]  load_data_ff;
	logic        abort_ff;
	logic        ck_oe_n_ff;
	logic        dt_oe_n_ff;
	logic        wr_go;
	logic        hold_wr;
	logic        tx_ok;
	logic        rx_dir;
	logic        xfer;
	logic        trmt;
	logic [7:0]  rd_val;

	ssm_if bus ();

	// accepted addresses; the shift register is deliberately absent
	function automatic logic reg_hit(input logic [4:0] a);
		reg_hit = (a == ssm_pkg::ADDR_TXCTL) || (a == ssm_pkg::ADDR_RXCTL) ||
			(a == ssm_pkg::ADDR_DIV) || (a == ssm_pkg::ADDR_HOLD) ||
			(a == ssm_pkg::ADDR_STAT); // RULE19
	endfunction

	// ==========================================
	// reset release and pin synchronisers
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rst_meta_ff <= 1'b0;
			rst_n       <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n       <= rst_meta_ff;
		end
	end

	// only the second and third stages feed the edge detector
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			ck_s1_ff <= 1'b0;
			ck_s2_ff <= 1'b0;
			ck_s3_ff <= 1'b0;
			dt_s1_ff <= 1'b0;
			dt_s2_ff <= 1'b0;
		end else begin
			ck_s1_ff <= CLOCK_PIN_IN;
			ck_s2_ff <= ck_s1_ff;
			ck_s3_ff <= ck_s2_ff;
			dt_s1_ff <= DATA_PIN_IN;
			dt_s2_ff <= dt_s1_ff;
		end
	end

	// ==========================================
	// write channels, taken in either order
	assign wr_go   = aw_done_ff & w_done_ff & ~bvalid_ff;
	assign hold_wr = wr_go & wstrb_ff & (aw_addr_ff == ssm_pkg::ADDR_HOLD); // RULE14

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			aw_addr_ff <= 5'h00;
			aw_done_ff <= 1'b0;
			awready_ff <= 1'b0;
		end else if (AWVALID && awready_ff) begin
			aw_addr_ff <= AWADDR;
			aw_done_ff <= 1'b1;
			awready_ff <= 1'b0;
		end else if (bvalid_ff && BREADY) begin
			aw_done_ff <= 1'b0;
		end else if (!aw_done_ff && !bvalid_ff) begin
			awready_ff <= 1'b1;
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			wdata_ff  <= 8'h00;
			wstrb_ff  <= 1'b0;
			w_done_ff <= 1'b0;
			wready_ff <= 1'b0;
		end else if (WVALID && wready_ff) begin
			wdata_ff  <= WDATA[7:0];
			wstrb_ff  <= WSTRB[0];
			w_done_ff <= 1'b1;
			wready_ff <= 1'b0;
		end else if (bvalid_ff && BREADY) begin
			w_done_ff <= 1'b0;
		end else if (!w_done_ff && !bvalid_ff) begin
			wready_ff <= 1'b1;
		end
	end

	// response follows both halves; unmapped addresses get an error
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= ssm_pkg::RESP_OK;
		end else if (wr_go) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= reg_hit(aw_addr_ff) ? ssm_pkg::RESP_OK : ssm_pkg::RESP_ERR;
		end else if (bvalid_ff && BREADY) begin
			bvalid_ff <= 1'b0;
		end
	end

	// ==========================================
	// control registers; byte lane 0 only, upper lanes ignored
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			txctl_ff <= ssm_pkg::REG_RST;
			rxctl_ff <= ssm_pkg::REG_RST;
			div_ff   <= ssm_pkg::REG_RST;
		end else if (wr_go && wstrb_ff) begin
			if (aw_addr_ff == ssm_pkg::ADDR_TXCTL) begin
				txctl_ff <= wdata_ff & ssm_pkg::TXCTL_WMASK;
			end
			if (aw_addr_ff == ssm_pkg::ADDR_RXCTL) begin
				rxctl_ff <= wdata_ff & ssm_pkg::RXCTL_WMASK;
			end
			if (aw_addr_ff == ssm_pkg::ADDR_DIV) begin
				div_ff <= wdata_ff; // RULE22
			end
		end
	end

	// ==========================================
	// mode decode
	assign rx_dir = rxctl_ff[ssm_pkg::RX_SINGLE_RECEIVE_ENABLE] | rxctl_ff[ssm_pkg::RX_CONTINUOUS_RECEIVE_ENABLE]; // RULE8
	assign tx_ok  = rxctl_ff[ssm_pkg::RX_PORT_ENABLE] & txctl_ff[ssm_pkg::TX_SYNC] & // RULE9 RULE6
		txctl_ff[ssm_pkg::TX_EN] & ~rx_dir; // RULE20
	assign trmt   = ~bus.busy & ~load_ff;

	// ==========================================
	// holding register; a write in the transfer cycle still sets full
	assign xfer = hold_full_ff & tx_ok & ~bus.busy & ~load_ff; // RULE15 RULE16

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			hold_ff      <= 8'h00;
			hold_full_ff <= 1'b0;
		end else if (hold_wr) begin
			hold_ff      <= wdata_ff;
			hold_full_ff <= 1'b1;
		end else if (xfer) begin
			hold_full_ff <= 1'b0;
		end
	end

	// ninth bit is sampled at transfer, so it must be loaded beforehand
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			load_ff      <= 1'b0;
			load_data_ff <= 9'h000;
		end else begin
			load_ff <= xfer; // RULE16
			if (xfer) begin
				load_data_ff <= {txctl_ff[ssm_pkg::TX_N9D], hold_ff}; // RULE21
			end
		end
	end

	// dropping any enable stops the shifter mid character
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			abort_ff <= 1'b1;
		end else begin
			abort_ff <= ~tx_ok; // RULE9 RULE20
		end
	end

	// ==========================================
	// pin drivers, active low enables
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			ck_oe_n_ff <= 1'b1;
			dt_oe_n_ff <= 1'b1;
		end else begin
			ck_oe_n_ff <= ~(rxctl_ff[ssm_pkg::RX_PORT_ENABLE] & txctl_ff[ssm_pkg::TX_SYNC] &
				txctl_ff[ssm_pkg::TX_CSM]); // RULE10 RULE7
			dt_oe_n_ff <= ~tx_ok; // RULE13 RULE2
		end
	end

	// ==========================================
	// read channel, one cycle answer
	always_comb begin
		rd_val = 8'h00;
		case (ARADDR)
			ssm_pkg::ADDR_TXCTL: rd_val = {txctl_ff[7:2], trmt, txctl_ff[0]};
			ssm_pkg::ADDR_RXCTL: rd_val = rxctl_ff;
			ssm_pkg::ADDR_DIV:   rd_val = div_ff;
			ssm_pkg::ADDR_HOLD:  rd_val = hold_ff;
			ssm_pkg::ADDR_STAT:  rd_val = {5'h00, dt_s2_ff, trmt, ~hold_full_ff};
			default:             rd_val = 8'h00;
		endcase
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
			rresp_ff   <= ssm_pkg::RESP_OK;
			rdata_ff   <= 32'h0000_0000;
		end else if (ARVALID && arready_ff) begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b1;
			rresp_ff   <= reg_hit(ARADDR) ? ssm_pkg::RESP_OK : ssm_pkg::RESP_ERR; // RULE19
			rdata_ff   <= {24'h00_0000, rd_val};
		end else if (rvalid_ff && RREADY) begin
			rvalid_ff <= 1'b0;
		end else if (!rvalid_ff) begin
			arready_ff <= 1'b1;
		end
	end

	// ==========================================
	// submodules and carrier hookup
	assign bus.divisor    = div_ff;
	assign bus.high_speed = txctl_ff[ssm_pkg::TX_HSB]; // RULE22
	assign bus.load       = load_ff;
	assign bus.load_data  = load_data_ff;
	assign bus.nine       = txctl_ff[ssm_pkg::TX_N9]; // RULE21
	assign bus.master     = txctl_ff[ssm_pkg::TX_CSM]; // RULE7
	assign bus.ext_rise   = ck_s2_ff & ~ck_s3_ff; // RULE5
	assign bus.ext_fall   = ~ck_s2_ff & ck_s3_ff;
	assign bus.abort      = abort_ff;

	ssm_baud u_baud (
		.clk   (CLK),
		.rst_n (rst_n),
		.bus   (bus)
	);

	ssm_shift u_shift (
		.clk   (CLK),
		.rst_n (rst_n),
		.bus   (bus)
	);

	// ==========================================
	// outputs, all from flip-flops
	assign AWREADY        = awready_ff;
	assign WREADY         = wready_ff;
	assign BVALID         = bvalid_ff;
	assign BRESP          = bresp_ff;
	assign ARREADY        = arready_ff;
	assign RVALID         = rvalid_ff;
	assign RRESP          = rresp_ff;
	assign RDATA          = rdata_ff;
	assign CLOCK_PIN_OUT  = bus.sck; // RULE10
	assign CLOCK_PIN_OE_N = ck_oe_n_ff;
	assign DATA_PIN_OUT   = bus.sdo; // RULE18
	assign DATA_PIN_OE_N  = dt_oe_n_ff;

	// ==========================================
	// checks
	logic [3:0] edge_cnt_ff;
	logic       sck_q_ff;
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			edge_cnt_ff <= 4'h0;
			sck_q_ff    <= 1'b0;
		end else begin
			sck_q_ff <= CLOCK_PIN_OUT;
			if (load_ff) begin
				edge_cnt_ff <= 4'h0;
			end else if (CLOCK_PIN_OUT && !sck_q_ff) begin
				edge_cnt_ff <= edge_cnt_ff + 4'h1;
			end
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!rst_n);

	chk_clock_idle: assert property (!bus.busy |-> !CLOCK_PIN_OUT) // RULE12
		else $error("shift clock active while idle");
	chk_bit_count: assert property (($fell(bus.busy) && !abort_ff && bus.master)
		|-> edge_cnt_ff == (bus.nine ? 4'h9 : 4'h8)) // RULE12 RULE23
		else $error("wrong number of clock cycles for a character");
	chk_clock_oe: assert property ((rxctl_ff[ssm_pkg::RX_PORT_ENABLE] && txctl_ff[ssm_pkg::TX_SYNC] &&
		txctl_ff[ssm_pkg::TX_CSM])
		|=> !CLOCK_PIN_OE_N) // RULE10
		else $error("clock driver not enabled in master mode");
	chk_data_oe: assert property (tx_ok |=> !DATA_PIN_OE_N) // RULE13
		else $error("data driver not enabled while transmitting");
	chk_hold_load: assert property (xfer |=> load_ff ##1 (bus.busy || abort_ff)) // RULE16
		else $error("held character not moved to shifter");
	chk_hold_wait: assert property (bus.busy |=> !load_ff) // RULE15
		else $error("load while shifter still busy");
	chk_data_lead: assert property ((bus.master && bus.busy && $changed(DATA_PIN_OUT))
		|-> $rose(CLOCK_PIN_OUT)) // RULE11 RULE18
		else $error("data changed away from a leading edge");
	chk_tx_gate: assert property (!tx_ok |-> ##2 !bus.busy) // RULE9 RULE20
		else $error("shifter running while transmit not allowed");
	chk_start_now: assert property ((load_ff && !abort_ff) |=> bus.busy) // RULE17
		else $error("shifting did not start after load");

	cov_nine_bit: cover property (load_ff && bus.nine);
	cov_back_to_back: cover property (bus.busy && hold_full_ff ##[1:400] load_ff);
	cov_slave_char: cover property (!bus.master && $fell(bus.busy) && !abort_ff);
	cov_abort: cover property (bus.busy && abort_ff);
endmodule
`default_nettype wire

// file: verif/ssm_slave_model.sv
// slave device model listening to the master clock on the shared link
`timescale 1ns/1ps
`default_nettype none
module ssm_slave_model (
	input  wire logic       ck,
	input  wire logic       dt,
	output var  logic [8:0] shreg,
	output var  int         nbits
);
	// ==========
	// receive side only
	// never drives the data line, so the master owns it for the whole transfer
	initial begin
		shreg = 9'h000;
		nbits = 0;
	end
	// shift only on the master's trailing edge; data has been settled since the leading one
	always @(negedge ck) begin
		shreg <= {dt, shreg[8:1]};
		nbits <= nbits + 1;
	end
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// self-checking testbench for the synchronous serial master transmitter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clk = 1'b0;
	logic        ext_ck = 1'b0;
	logic        rst_n = 1'b0;
	logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic        ck_out, ck_oe_n, dt_out, dt_oe_n, ck_w, dt_w, ck_q, dt_q, oe_q;
	logic [8:0]  shreg;
	logic [7:0]  txc [4] = '{8'h94, 8'hB4, 8'hB4, 8'hA4};
	logic [7:0]  rxc [4] = '{8'h80, 8'h00, 8'hA0, 8'h80};
	logic [7:0]  dch [4] = '{8'h11, 8'h22, 8'h44, 8'h88};
	logic        ckoe [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
	int          nbits, r0, b0, rises = 0, cyc = 0, last_rise = 0, prev_rise = 0;
	int          stab_err = 0, miscompares = 0, samples_checked = 0;

	always #4 clk = ~clk;
	// a released clock line carries the bench's link clock, which idles low
	assign ck_w = ck_oe_n ? ext_ck : ck_out;
	// pull-up on the data line
	assign dt_w = dt_oe_n ? 1'b1 : dt_out;

	ssm_top i_dut (
		.CLK(clk), .RESET_N(rst_n), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
		.WDATA(wdata), .WSTRB(4'h1), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
		.BVALID(bvalid), .BREADY(1'b1), .ARADDR(araddr), .ARVALID(arvalid),
		.ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(1'b1),
		.CLOCK_PIN_IN(ck_w), .CLOCK_PIN_OUT(ck_out), .CLOCK_PIN_OE_N(ck_oe_n),
		.DATA_PIN_IN(dt_w), .DATA_PIN_OUT(dt_out), .DATA_PIN_OE_N(dt_oe_n)
	);
	ssm_slave_model i_slave (.ck(ck_w), .dt(dt_w), .shreg(shreg), .nbits(nbits));

	// ==========
	// link monitor
	// sampled mid-cycle so every flop of the design has settled
	always @(negedge clk) begin
		cyc <= cyc + 1;
		ck_q <= ck_w;
		dt_q <= dt_w;
		oe_q <= dt_oe_n;
		if (ck_w && !ck_q) begin
			rises <= rises + 1;
			prev_rise <= last_rise;
			last_rise <= cyc;
		end else if (!dt_oe_n && !oe_q && dt_w !== dt_q) begin
			stab_err <= stab_err + 1;
		end
		if (cyc == 20000) begin
			miscompares = miscompares + 1;
			final_report();
		end
	end

	// ==========
	// helpers
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		samples_checked = samples_checked + 1;
		if (s !== e) begin
			miscompares = miscompares + 1;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask

	// both channels offered together, each released at its own handshake edge
	task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
		logic ah, wh, sa, sw;
		ah = 1'b0;
		wh = 1'b0;
		awaddr <= a;
		wdata <= {24'h00_0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(ah && wh)) begin
			@(negedge clk);
			sa = awvalid && awready;
			sw = wvalid && wready;
			@(posedge clk);
			if (sa) begin
				ah = 1'b1;
				awvalid <= 1'b0;
			end
			if (sw) begin
				wh = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(negedge clk); while (!bvalid);
		chk("bresp", bresp, er);
		@(posedge clk);
	endtask

	task automatic rd(input logic [4:0] a, input logic [7:0] e, input logic [1:0] er);
		logic h;
		h = 1'b0;
		araddr <= a;
		arvalid <= 1'b1;
		while (!h) begin
			@(negedge clk);
			h = arready;
			@(posedge clk);
		end
		arvalid <= 1'b0;
		do @(negedge clk); while (!rvalid);
		chk("rdata", rdata, {24'h00_0000, e});
		chk("rresp", rresp, er);
		@(posedge clk);
	endtask

	// one character: start lag, edge count and received value
	task automatic go(input logic [7:0] d, input logic [8:0] e, input int nb, input int lim);
		int n;
		n = 0;
		b0 = nbits;
		r0 = rises;
		wr(ssm_pkg::ADDR_HOLD, d, ssm_pkg::RESP_OK);
		while (rises == r0) begin
			@(posedge clk);
			n = n + 1;
		end
		chk("start_lag", n <= lim, 1);
		while (nbits < b0 + nb) @(posedge clk);
		repeat (40) @(posedge clk);
		chk("edges", rises - r0, nb);
		chk("char", (nb == 9) ? shreg : {1'b0, shreg[8:1]}, e);
	endtask

	task automatic final_report();
		if (miscompares == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// ==========
	// main sequence
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		rd(ssm_pkg::ADDR_TXCTL, 8'h02, ssm_pkg::RESP_OK);
		rd(ssm_pkg::ADDR_RXCTL, 8'h00, ssm_pkg::RESP_OK);
		rd(ssm_pkg::ADDR_DIV, 8'h00, ssm_pkg::RESP_OK);
		rd(ssm_pkg::ADDR_STAT, 8'h07, ssm_pkg::RESP_OK);
		rd(5'h14, 8'h00, ssm_pkg::RESP_ERR);
		rd(5'h1C, 8'h00, ssm_pkg::RESP_ERR);
		wr(5'h18, 8'hFF, ssm_pkg::RESP_ERR);
		wr(ssm_pkg::ADDR_RXCTL, 8'h80, ssm_pkg::RESP_OK);
		// slave setup first: the clock pin must stay released
		wr(ssm_pkg::ADDR_TXCTL, 8'h34, ssm_pkg::RESP_OK);
		@(posedge clk);
		chk("ck_oe_slave", ck_oe_n, 1);
		wr(ssm_pkg::ADDR_TXCTL, 8'hB4, ssm_pkg::RESP_OK);
		// enables follow the register one edge after the write lands
		@(posedge clk);
		chk("ck_oe_master", ck_oe_n, 0);
		chk("dt_oe_master", dt_oe_n, 0);
		rd(ssm_pkg::ADDR_TXCTL, 8'hB6, ssm_pkg::RESP_OK);
		go(8'hA5, 9'h0A5, 8, 8);
		// back to back: the second character has to wait for the first
		b0 = nbits;
		r0 = rises;
		wr(ssm_pkg::ADDR_HOLD, 8'h3C, ssm_pkg::RESP_OK);
		wr(ssm_pkg::ADDR_HOLD, 8'hC3, ssm_pkg::RESP_OK);
		while (nbits < b0 + 8) @(posedge clk);
		chk("first_char", shreg[8:1], 8'h3C);
		while (nbits < b0 + 16) @(posedge clk);
		repeat (40) @(posedge clk);
		chk("second_char", shreg[8:1], 8'hC3);
		chk("pair_edges", rises - r0, 16);
		wr(ssm_pkg::ADDR_TXCTL, 8'hF5, ssm_pkg::RESP_OK);
		go(8'h5A, 9'h15A, 9, 8);
		// each blocking setup must hold the character back until cleared
		for (int i = 0; i < 4; i++) begin
			r0 = rises;
			wr(ssm_pkg::ADDR_TXCTL, txc[i], ssm_pkg::RESP_OK);
			wr(ssm_pkg::ADDR_RXCTL, rxc[i], ssm_pkg::RESP_OK);
			wr(ssm_pkg::ADDR_HOLD, dch[i], ssm_pkg::RESP_OK);
			repeat (60) @(posedge clk);
			chk("idle_edges", rises - r0, 0);
			chk("ck_oe_blocked", ck_oe_n, ckoe[i]);
			chk("dt_oe_blocked", dt_oe_n, 1);
			rd(ssm_pkg::ADDR_STAT, 8'h06, ssm_pkg::RESP_OK);
			b0 = nbits;
			wr(ssm_pkg::ADDR_RXCTL, 8'h80, ssm_pkg::RESP_OK);
			wr(ssm_pkg::ADDR_TXCTL, 8'hB4, ssm_pkg::RESP_OK);
			while (nbits < b0 + 8) @(posedge clk);
			chk("held_char", shreg[8:1], dch[i]);
		end
		// slow prescale: half period (2+1)*4 cycles
		wr(ssm_pkg::ADDR_DIV, 8'h02, ssm_pkg::RESP_OK);
		wr(ssm_pkg::ADDR_TXCTL, 8'hB0, ssm_pkg::RESP_OK);
		go(8'h96, 9'h096, 8, 20);
		chk("bit_period", last_rise - prev_rise, 24);
		// dropping transmit enable mid character must stop the clock at once
		wr(ssm_pkg::ADDR_HOLD, 8'hF0, ssm_pkg::RESP_OK);
		repeat (40) @(posedge clk);
		wr(ssm_pkg::ADDR_TXCTL, 8'h90, ssm_pkg::RESP_OK);
		repeat (3) @(posedge clk);
		r0 = rises;
		repeat (60) @(posedge clk);
		chk("abort_edges", rises - r0, 0);
		chk("abort_dt_oe", dt_oe_n, 1);
		rd(ssm_pkg::ADDR_STAT, 8'h07, ssm_pkg::RESP_OK);
		chk("data_stable", stab_err, 0);
		// slave mode: the bench runs the link clock, 160 ns a cycle, for one character
		wr(ssm_pkg::ADDR_TXCTL, 8'h34, ssm_pkg::RESP_OK);
		b0 = nbits;
		wr(ssm_pkg::ADDR_HOLD, 8'h69, ssm_pkg::RESP_OK);
		repeat (8) begin
			repeat (10) @(posedge clk);
			ext_ck <= 1'b1;
			repeat (10) @(posedge clk);
			ext_ck <= 1'b0;
		end
		repeat (10) @(posedge clk);
		chk("slave_char", shreg[8:1], 8'h69);
		chk("slave_bits", nbits - b0, 8);
		rd(ssm_pkg::ADDR_TXCTL, 8'h36, ssm_pkg::RESP_OK);
		final_report();
	end
endmodule
`default_nettype wire
